//--- cbi_pkg.sv
// constants for the cpu bus and interrupt pin controller
// assumes a single 100 MHz ref_clk that stands for the crystal input
package cbi_pkg;
	// register byte offsets
	localparam logic [7:0] CBI_OFS_CMD  = 8'h00;
	localparam logic [7:0] CBI_OFS_ADDR = 8'h04;
	localparam logic [7:0] CBI_OFS_DATA = 8'h08;
	localparam logic [7:0] CBI_OFS_MASK = 8'h0C;
	localparam logic [7:0] CBI_OFS_STAT = 8'h10;
	// command register bits (write only, self clearing)
	localparam int CBI_CMD_RD     = 0;
	localparam int CBI_CMD_WR     = 1;
	localparam int CBI_CMD_IO     = 2;
	localparam int CBI_CMD_EI     = 3;
	localparam int CBI_CMD_DI     = 4;
	localparam int CBI_CMD_SAMPLE = 5;
	localparam int CBI_CMD_HALT   = 6;
	localparam int CBI_CMD_TKCLR  = 7;
	localparam int CBI_CMD_INC    = 8;
	// set-mask write layout
	localparam int CBI_SIM_M55  = 0;
	localparam int CBI_SIM_M75  = 2;
	localparam int CBI_SIM_MSE  = 3;
	localparam int CBI_SIM_R75C = 4;
	localparam int CBI_SIM_SDE  = 6;
	localparam int CBI_SIM_SOD  = 7;
	// read-mask layout
	localparam int CBI_RIM_IE  = 3;
	localparam int CBI_RIM_P55 = 4;
	localparam int CBI_RIM_P75 = 6;
	localparam int CBI_RIM_SID = 7;
	// status layout
	localparam int CBI_ST_BUSY  = 0;
	localparam int CBI_ST_BUS_GRANT_ACK  = 1;
	localparam int CBI_ST_HALT  = 2;
	localparam int CBI_ST_TAKEN = 3;
	localparam int CBI_ST_VEC   = 8;
	// restart vectors, zero means instruction supplied externally
	localparam logic [7:0] CBI_VEC_NMI  = 8'h24;
	localparam logic [7:0] CBI_VEC_R75  = 8'h3C;
	localparam logic [7:0] CBI_VEC_R65  = 8'h34;
	localparam logic [7:0] CBI_VEC_R55  = 8'h2C;
	localparam logic [7:0] CBI_VEC_EXT  = 8'h00;
	// reset values, crystal divider and bus state encoding
	localparam logic [15:0] CBI_ADDR_RST = 16'h0000;
	localparam logic [2:0]  CBI_MASK_RST = 3'h7;
	localparam int CBI_XTAL_DIV = 2;
	typedef enum logic [2:0] {
		CBI_IDLE = 3'b000,
		CBI_T1   = 3'b001,
		CBI_T2   = 3'b010,
		CBI_TW   = 3'b011,
		CBI_T3   = 3'b100
	} cbi_state_t;
endpackage : cbi_pkg

//--- cbi_ctrl.sv
// cpu bus cycle, hold and interrupt pin controller with an ahb-lite slave
// assumes ref_clk is the crystal input and all pins are asynchronous to it
//
// Notes on behaviour
// R1: read strobe low requests data; floated in hold, halt and reset.
// R2: write strobe low writes; data stands until the strobe rises.
// R3: ready low stretches the cycle by whole clock states.
// R4: hold request is granted only after the current transfer ends.
// R5: during hold, address, data, strobes and io select float.
// R6: grant asserts, bus floats one clock state later.
// R7: request removed drops grant; bus driven half a state later.
// R8: interrupts sampled at software marker and during hold or halt.
// R9: accepted general irq stops address increment, runs acknowledge cycle.
// R10: software enables interrupts; reset and acceptance disable them.
// R11: acknowledge strobe replaces read strobe with identical timing.
// R12: restart inputs rank above general irq, vector internally.
// R13: each restart input has its own mask bit.
// R14: nonmaskable input ignores masks and enable, highest priority.
// R15: reset input clears address counter, enable and grant.
// R16: during reset input all bus and control lines float.
// R17: reset out follows reset input in whole clock periods.
// R18: crystal input divided by two forms the clock output.
// R19: each mask read copies serial input into bit 7.
// R20: serial output set by mask write and held.
// R21: low address in first state, data in later states.
// R22: fixed priority nmi, 7.5, 6.5, 5.5, general irq.
// R23: restart vectors 24H, 3CH, 34H, 2CH.
`timescale 1ns/10ps
`default_nettype none
module cbi_ctrl
	import cbi_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [7:0]  addr_hi,
	output logic             addr_hi_oe,
	output logic      [7:0]  ad_out,
	output logic             ad_oe,
	input  wire logic [7:0]  ad_in,
	output logic             addr_latch_en,
	output logic             read_strobe_n,
	output logic             write_strobe_n,
	output logic             io_or_memory_select,
	output logic             ctl_oe,
	output logic             irq_ack_n,
	input  wire logic        ready_in,
	input  wire logic        hold_req,
	output logic             bus_grant_ack,
	input  wire logic        general_irq,
	input  wire logic [2:0]  restart_irq,
	input  wire logic        nonmaskable_irq,
	input  wire logic        reset_input,
	output logic             system_reset_out,
	output logic             clk_out,
	input  wire logic        serial_in_line,
	output logic             serial_out_line
);
	localparam int NS = 17;
	// two flop synchronisers for every pin input
	logic [NS-1:0] s1_reg, s2_reg, pins;
	assign pins = {ad_in, serial_in_line, reset_input, nonmaskable_irq,
		restart_irq, general_irq, hold_req, ready_in};
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
		end
	end
	logic       rdy_s, hold_s, gi_s, nmi_s, rst_s, sid_s;
	logic [2:0] rsi_s;
	logic [7:0] adi_s;
	assign {adi_s, sid_s, rst_s, nmi_s, rsi_s, gi_s, hold_s, rdy_s} = s2_reg;

	cbi_state_t st_reg, st_next;
	logic [15:0] addr_reg, addr_next;
	logic [7:0]  wd_reg, wd_next, rd_reg, rd_next, vec_reg, vec_next;
	logic [2:0]  mask_reg, mask_next;
	logic tick_reg, tick_next, clko_reg, clko_next;
	logic go_reg, go_next, wr_reg, wr_next, io_reg, io_next;
	logic irq_ack_n_reg, irq_ack_n_next, inc_reg, inc_next;
	logic bus_grant_ack_reg, bus_grant_ack_next, flt_reg, flt_next, halt_reg, halt_next;
	logic ie_reg, ie_next, tk_reg, tk_next;
	logic trp_ff, trp_next, trp_prev, r75_ff, r75_next, r75_prev;
	logic sod_reg, sod_next, rso_reg, rso_next;
	logic ale_reg, ale_next, rdn_reg, rdn_next, wrn_reg, wrn_next;
	logic ian_reg, ian_next, iom_reg, iom_next;
	logic [7:0] ah_reg, ah_next, ado_reg, ado_next;
	logic aoe_reg, aoe_next, cen_reg, cen_next;
	// ahb slave state
	logic        dw_reg, dw_next, rp_reg, rp_next, hr_reg, hr_next;
	logic [7:0]  ha_reg, ha_next;
	logic [31:0] hd_reg, hd_next;
	logic        acc, t_adv, smp, busy;
	logic [31:0] rv;

	assign acc   = hsel && htrans[1] && hready;
	assign t_adv = tick_reg;
	assign busy  = (st_reg != CBI_IDLE) || go_reg;

	// read value mux; mask reads catch serial input at this moment
	always_comb begin
		rv = 32'h0000_0000;
		unique case (ha_reg)
			CBI_OFS_ADDR: rv[15:0] = addr_reg;
			CBI_OFS_DATA: rv[7:0] = rd_reg;
			CBI_OFS_MASK: begin
				rv[CBI_SIM_M75:CBI_SIM_M55] = mask_reg;
				rv[CBI_RIM_IE] = ie_reg;
				rv[CBI_RIM_P55] = rsi_s[0];
				rv[CBI_RIM_P55+1] = rsi_s[1];
				rv[CBI_RIM_P75] = r75_ff;
				// R19 serial in to bit 7
				rv[CBI_RIM_SID] = sid_s;
			end
			CBI_OFS_STAT: begin
				rv[CBI_ST_BUSY] = busy;
				rv[CBI_ST_BUS_GRANT_ACK] = bus_grant_ack_reg;
				rv[CBI_ST_HALT] = halt_reg;
				rv[CBI_ST_TAKEN] = tk_reg;
				rv[CBI_ST_VEC+7:CBI_ST_VEC] = vec_reg;
			end
			default: rv = 32'h0000_0000;
		endcase
	end

	// bus slave: writes in zero wait, reads take one wait so hrdata is a flop
	always_comb begin
		dw_next = 1'b0;
		rp_next = 1'b0;
		hr_next = 1'b1;
		ha_next = ha_reg;
		hd_next = hd_reg;
		if (rp_reg) begin
			hd_next = rv;
		end else if (acc) begin
			ha_next = haddr[7:0];
			dw_next = hwrite;
			rp_next = !hwrite;
			hr_next = hwrite;
		end
	end

	// core: divider, bus cycles, hold, interrupts
	always_comb begin
		logic [8:0] cmd;
		logic       wen;
		cmd = 9'h000;
		wen = dw_reg;
		st_next = st_reg;
		addr_next = addr_reg;
		wd_next = wd_reg;
		rd_next = rd_reg;
		vec_next = vec_reg;
		mask_next = mask_reg;
		go_next = go_reg;
		wr_next = wr_reg;
		io_next = io_reg;
		irq_ack_n_next = irq_ack_n_reg;
		inc_next = inc_reg;
		bus_grant_ack_next = bus_grant_ack_reg;
		halt_next = halt_reg;
		ie_next = ie_reg;
		tk_next = tk_reg;
		sod_next = sod_reg;
		trp_next = trp_ff;
		r75_next = r75_ff;
		// R18 half rate clock and state enable
		tick_next = !tick_reg;
		clko_next = tick_reg;
		// R17 reset out in whole periods
		rso_next = (t_adv) ? rst_s : rso_reg;
		if (wen && ha_reg == CBI_OFS_CMD) begin
			cmd = hwdata[8:0];
		end
		if (wen && ha_reg == CBI_OFS_ADDR) begin
			addr_next = hwdata[15:0];
		end
		if (wen && ha_reg == CBI_OFS_DATA) begin
			wd_next = hwdata[7:0];
		end
		if (wen && ha_reg == CBI_OFS_MASK) begin
			// R13 masks only when mask-set enable is high
			if (hwdata[CBI_SIM_MSE]) begin
				mask_next = hwdata[CBI_SIM_M75:CBI_SIM_M55];
			end
			if (hwdata[CBI_SIM_R75C]) begin
				r75_next = 1'b0;
			end
			// R20 serial out held until next enabled write
			if (hwdata[CBI_SIM_SDE]) begin
				sod_next = hwdata[CBI_SIM_SOD];
			end
		end
		// R10 software enable and disable
		if (cmd[CBI_CMD_EI]) ie_next = 1'b1;
		if (cmd[CBI_CMD_DI]) ie_next = 1'b0;
		if (cmd[CBI_CMD_TKCLR]) tk_next = 1'b0;
		if (cmd[CBI_CMD_HALT] && !busy) halt_next = 1'b1;
		if ((cmd[CBI_CMD_RD] || cmd[CBI_CMD_WR]) && !busy && !tk_reg) begin
			go_next = 1'b1;
			wr_next = cmd[CBI_CMD_WR];
			io_next = cmd[CBI_CMD_IO];
			inc_next = cmd[CBI_CMD_INC];
			irq_ack_n_next = 1'b0;
		end
		// edge latches set after the mask-write clear so a coincident edge is kept; acceptance and reset clears come later
		if (rsi_s[2] && !r75_prev) r75_next = 1'b1;
		if (nmi_s && !trp_prev) trp_next = 1'b1;
		if (!nmi_s) trp_next = 1'b0;
		// R8 sample points
		smp = cmd[CBI_CMD_SAMPLE] || (t_adv && (bus_grant_ack_reg || halt_reg));
		if (smp && !tk_reg) begin
			// R22 fixed priority, R14 nmi ignores masks and enable
			if (trp_ff && nmi_s) begin
				trp_next = 1'b0;
				vec_next = CBI_VEC_NMI;
				tk_next = 1'b1;
			end else if (ie_reg && r75_ff && !mask_reg[2]) begin
				// R12 restart vectored internally, R23 vectors
				r75_next = 1'b0;
				vec_next = CBI_VEC_R75;
				tk_next = 1'b1;
			end else if (ie_reg && rsi_s[1] && !mask_reg[1]) begin
				vec_next = CBI_VEC_R65;
				tk_next = 1'b1;
			end else if (ie_reg && rsi_s[0] && !mask_reg[0]) begin
				vec_next = CBI_VEC_R55;
				tk_next = 1'b1;
			end else if (ie_reg && gi_s && !busy && !bus_grant_ack_reg) begin
				// R9 acknowledge cycle, no address increment
				vec_next = CBI_VEC_EXT;
				tk_next = 1'b1;
				go_next = 1'b1;
				irq_ack_n_next = 1'b1;
				wr_next = 1'b0;
				io_next = 1'b1;
				inc_next = 1'b0;
			end
			if (tk_next) begin
				// R10 acceptance disables interrupts
				ie_next = 1'b0;
				halt_next = 1'b0;
			end
		end
		if (t_adv) begin
			unique case (st_reg)
				CBI_IDLE: begin
					// R4 grant only between transfers
					if (hold_s && !bus_grant_ack_reg) begin
						bus_grant_ack_next = 1'b1;
					end else if (!hold_s && bus_grant_ack_reg) begin
						// R7 grant drops when request removed
						bus_grant_ack_next = 1'b0;
					end else if (go_reg && !bus_grant_ack_reg && !halt_reg) begin
						go_next = 1'b0;
						st_next = CBI_T1;
					end
				end
				CBI_T1: st_next = CBI_T2;
				// R3 whole wait states while ready low
				CBI_T2: st_next = rdy_s ? CBI_T3 : CBI_TW;
				CBI_TW: st_next = rdy_s ? CBI_T3 : CBI_TW;
				CBI_T3: begin
					st_next = CBI_IDLE;
					if (!wr_reg) rd_next = adi_s;
					if (inc_reg) addr_next = addr_reg + 16'h0001;
				end
			endcase
		end
		// R15 reset input clears counter, enable and grant
		if (rst_s) begin
			st_next = CBI_IDLE;
			addr_next = CBI_ADDR_RST;
			mask_next = CBI_MASK_RST;
			go_next = 1'b0;
			bus_grant_ack_next = 1'b0;
			halt_next = 1'b0;
			ie_next = 1'b0;
			tk_next = 1'b0;
			r75_next = 1'b0;
			trp_next = 1'b0;
		end
		// R6 float a state after grant; R7 drive half a state after drop
		flt_next = bus_grant_ack_reg && (flt_reg || t_adv);
		// R21 low address in first state, data afterwards
		ah_next = addr_next[15:8];
		ale_next = (st_next == CBI_T1);
		ado_next = (st_next == CBI_T1) ? addr_next[7:0] : wd_next;
		aoe_next = (st_next == CBI_T1) || ((st_next != CBI_IDLE) && wr_next);
		// R1 R2 R11 strobes low from second state to end of third
		rdn_next = !((st_next != CBI_IDLE) && (st_next != CBI_T1) && !wr_next && !irq_ack_n_next);
		wrn_next = !((st_next != CBI_IDLE) && (st_next != CBI_T1) && wr_next);
		ian_next = !((st_next != CBI_IDLE) && (st_next != CBI_T1) && irq_ack_n_next);
		iom_next = (st_next == CBI_IDLE) ? iom_reg : io_next;
		// R5 R16 float in hold, halt and reset
		cen_next = !flt_next && !halt_next && !rst_s;
		if (!cen_next) aoe_next = 1'b0;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dw_reg <= 1'b0;
			rp_reg <= 1'b0;
			hr_reg <= 1'b1;
			ha_reg <= 8'h00;
			hd_reg <= 32'h0000_0000;
			st_reg <= CBI_IDLE;
			addr_reg <= CBI_ADDR_RST;
			wd_reg <= 8'h00;
			rd_reg <= 8'h00;
			vec_reg <= 8'h00;
			mask_reg <= CBI_MASK_RST;
			{tick_reg, clko_reg, go_reg, wr_reg, io_reg} <= 5'h00;
			{irq_ack_n_reg, inc_reg, bus_grant_ack_reg, flt_reg, halt_reg} <= 5'h00;
			{ie_reg, tk_reg, trp_ff, trp_prev, r75_ff, r75_prev} <= 6'h00;
			{sod_reg, rso_reg, ale_reg, aoe_reg, cen_reg, iom_reg} <= 6'h00;
			{rdn_reg, wrn_reg, ian_reg} <= 3'h7;
			ah_reg <= 8'h00;
			ado_reg <= 8'h00;
		end else begin
			dw_reg <= dw_next;
			rp_reg <= rp_next;
			hr_reg <= hr_next;
			ha_reg <= ha_next;
			hd_reg <= hd_next;
			st_reg <= st_next;
			addr_reg <= addr_next;
			wd_reg <= wd_next;
			rd_reg <= rd_next;
			vec_reg <= vec_next;
			mask_reg <= mask_next;
			{tick_reg, clko_reg, go_reg, wr_reg, io_reg} <= {tick_next, clko_next, go_next, wr_next, io_next};
			{irq_ack_n_reg, inc_reg, bus_grant_ack_reg, flt_reg, halt_reg} <= {irq_ack_n_next, inc_next, bus_grant_ack_next, flt_next, halt_next};
			{ie_reg, tk_reg, trp_ff, r75_ff} <= {ie_next, tk_next, trp_next, r75_next};
			{trp_prev, r75_prev} <= {nmi_s, rsi_s[2]};
			{sod_reg, rso_reg, ale_reg, aoe_reg, cen_reg, iom_reg} <= {sod_next, rso_next, ale_next, aoe_next,
				cen_next, iom_next};
			{rdn_reg, wrn_reg, ian_reg} <= {rdn_next, wrn_next, ian_next};
			ah_reg <= ah_next;
			ado_reg <= ado_next;
		end
	end

	assign hrdata = hd_reg;
	assign hreadyout = hr_reg;
	assign hresp = 1'b0;
	assign addr_hi = ah_reg;
	assign addr_hi_oe = cen_reg;
	assign ad_out = ado_reg;
	assign ad_oe = aoe_reg;
	assign addr_latch_en = ale_reg;
	assign read_strobe_n = rdn_reg;
	assign write_strobe_n = wrn_reg;
	assign irq_ack_n = ian_reg;
	assign io_or_memory_select = iom_reg;
	assign ctl_oe = cen_reg;
	assign bus_grant_ack = bus_grant_ack_reg;
	assign system_reset_out = rso_reg;
	assign clk_out = clko_reg;
	assign serial_out_line = sod_reg;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence strobe_low_s;
		!wrn_reg [*2];
	endsequence
	// R1 read strobe floated while halted
	strobe_float_a: assert property (halt_reg |-> !cen_reg) else $error("strobes driven in halt"); // R1
	// R2 data stands while write strobe low
	wr_data_a: assert property (strobe_low_s |-> $stable(ado_reg) && aoe_reg) else $error("write data moved"); // R2
	// R3 wait state held while ready low
	wait_hold_a: assert property (st_reg == CBI_TW && !rdy_s && t_adv |=> st_reg == CBI_TW) else $error("wait lost"); // R3
	// R4 grant never taken mid transfer
	grant_idle_a: assert property ($rose(bus_grant_ack_reg) |-> $past(st_reg) == CBI_IDLE) else $error("grant mid cycle"); // R4
	// R6 float within one state of grant
	float_soon_a: assert property ($rose(bus_grant_ack_reg) |-> ##[1:2] flt_reg) else $error("bus not released"); // R6
	// R7 bus driven again one cycle after grant drops
	resume_a: assert property ($fell(bus_grant_ack_reg) && !halt_reg && !rst_s |=> !flt_reg) else $error("no resume"); // R7
	// R10 acceptance disables interrupts
	accept_dis_a: assert property ($rose(tk_reg) |-> !ie_reg) else $error("ie left on"); // R10
	// R11 read and acknowledge strobes never low together
	ack_excl_a: assert property (!(!rdn_reg && !ian_reg)) else $error("both strobes low"); // R11
	// R15 reset input clears grant and enable
	rst_clr_a: assert property (rst_s |=> !bus_grant_ack_reg && !ie_reg && addr_reg == CBI_ADDR_RST) else $error("reset miss"); // R15
	// R18 clock output low the cycle after it is high
	clk_div_a: assert property (clko_reg |=> !clko_reg) else $error("clock not divided"); // R18
endmodule : cbi_ctrl
`default_nettype wire

//--- cbi_mem_model.sv
// partner memory on the multiplexed bus: latches the address, serves reads,
// acknowledge bytes and writes; assumes the bench wires it to the controller
`timescale 1ns/10ps
`default_nettype none
module cbi_mem_model (
	input  wire logic       ref_clk,
	input  wire logic       addr_latch_en,
	input  wire logic [7:0] ad_out,
	input  wire logic [7:0] addr_hi,
	input  wire logic       read_strobe_n,
	input  wire logic       write_strobe_n,
	input  wire logic       irq_ack_n,
	input  wire logic       slow,
	output logic      [7:0] ad_in,
	output logic            ready_in
);
	logic [7:0] mem [256];
	logic [7:0] lat_addr;
	logic [7:0] lat_hi;
	logic [7:0] last;
	int         wait_cnt;
	initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'hA5;
	initial wait_cnt = 0;
	// released lines start from a known level so the toggle is defined
	initial last = 8'h00;
	// low byte taken in the first state
	always @(posedge ref_clk) begin
		if (addr_latch_en === 1'b1) begin
			lat_addr <= ad_out;
			lat_hi   <= addr_hi;
		end
		// last value before the strobe rises is kept
		if (write_strobe_n === 1'b0) mem[lat_addr] <= ad_out;
		wait_cnt <= (read_strobe_n & write_strobe_n & irq_ack_n) ? 0 : wait_cnt + 1;
		last     <= ad_in;
	end
	// slow mode holds ready low for a while
	assign ready_in = !(slow && wait_cnt < 6);
	// acknowledge supplies a restart byte; released lines toggle
	assign ad_in = !read_strobe_n ? mem[lat_addr] : !irq_ack_n ? 8'hFF : ~last;
endmodule : cbi_mem_model
`default_nettype wire

//--- cbi_ctrl_test.sv
// self-checking bench for the bus, hold and interrupt controller
// assumes the memory model answers the bus and the bench is the ahb master
`timescale 1ns/10ps
`default_nettype none
module cbi_ctrl_test;
	import cbi_pkg::*;
	logic        ref_clk, nrst, hsel, hwrite, hready, hreadyout, hresp, slow;
	logic [31:0] haddr, hwdata, hrdata, q, a0;
	logic [1:0]  htrans;
	logic [2:0]  hsize, restart_irq;
	logic [7:0]  addr_hi, ad_out, ad_in;
	logic        addr_hi_oe, ad_oe, addr_latch_en, read_strobe_n, write_strobe_n;
	logic        io_or_memory_select, ctl_oe, irq_ack_n, ready_in, hold_req;
	logic        bus_grant_ack, general_irq, nonmaskable_irq, reset_input;
	logic        system_reset_out, clk_out, serial_in_line, serial_out_line, c;
	int          miscompares, samples_checked, rd_low, ack_low, n;
	logic [7:0]  vecs [4];
	assign hready = hreadyout;
	cbi_ctrl uut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.addr_hi(addr_hi), .addr_hi_oe(addr_hi_oe), .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in),
		.addr_latch_en(addr_latch_en), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
		.io_or_memory_select(io_or_memory_select), .ctl_oe(ctl_oe), .irq_ack_n(irq_ack_n), .ready_in(ready_in),
		.hold_req(hold_req), .bus_grant_ack(bus_grant_ack), .general_irq(general_irq), .restart_irq(restart_irq),
		.nonmaskable_irq(nonmaskable_irq), .reset_input(reset_input), .system_reset_out(system_reset_out),
		.clk_out(clk_out), .serial_in_line(serial_in_line), .serial_out_line(serial_out_line));
	cbi_mem_model mem (.ref_clk(ref_clk), .addr_latch_en(addr_latch_en), .ad_out(ad_out),
		.addr_hi(addr_hi), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
		.irq_ack_n(irq_ack_n), .slow(slow), .ad_in(ad_in), .ready_in(ready_in));
	initial begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (read_strobe_n === 1'b0) rd_low++;
		if (irq_ack_n === 1'b0) ack_low++;
	end
	task wt(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : wt
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		hsize  <= 3'h2;
		haddr  <= {24'h0, a};
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb
	task cmd(input int b);
		ahb(1'b1, CBI_OFS_CMD, 32'h1 << b);
	endtask : cmd
	task idle;
		do ahb(1'b0, CBI_OFS_STAT, 32'h0); while (q[CBI_ST_BUSY] !== 1'b0);
	endtask : idle
	task t_reset;
		ahb(1'b0, CBI_OFS_ADDR, 32'h0);
		chk(q, {16'h0, CBI_ADDR_RST});
		ahb(1'b0, CBI_OFS_MASK, 32'h0);
		chk(q[3:0], {1'b0, CBI_MASK_RST});
		ahb(1'b0, CBI_OFS_STAT, 32'h0);
		chk(q[CBI_ST_BUS_GRANT_ACK], 1'b0);
		c = clk_out;
		wt(1);
		chk(clk_out, 1'(~c));
		wt(1);
		chk(clk_out, c);
		$display("reset test done");
	endtask : t_reset
	task t_bus;
		ahb(1'b1, CBI_OFS_ADDR, 32'h1234);
		ahb(1'b1, CBI_OFS_DATA, 32'hA5);
		cmd(CBI_CMD_WR);
		idle;
		chk(mem.mem[8'h34], 8'hA5);
		chk(mem.lat_hi, 8'h12);
		chk(io_or_memory_select, 1'b0);
		slow <= 1'b1;
		ahb(1'b1, CBI_OFS_ADDR, 32'h1235);
		n = rd_low;
		cmd(CBI_CMD_RD);
		idle;
		chk((rd_low - n > 4) && ((rd_low - n) % 2 == 0), 1'b1);
		ahb(1'b0, CBI_OFS_DATA, 32'h0);
		chk(q[7:0], 8'h35 ^ 8'hA5);
		slow <= 1'b0;
		n = rd_low;
		ahb(1'b1, CBI_OFS_CMD, (32'h1 << CBI_CMD_RD) | (32'h1 << CBI_CMD_INC));
		idle;
		chk(rd_low - n, 4);
		ahb(1'b0, CBI_OFS_ADDR, 32'h0);
		chk(q, 32'h1236);
		$display("bus test done");
	endtask : t_bus
	task t_hold;
		slow <= 1'b1;
		n = rd_low;
		cmd(CBI_CMD_RD);
		hold_req <= 1'b1;
		while (bus_grant_ack !== 1'b1) wt(1);
		chk(rd_low - n > 4, 1'b1);
		wt(4);
		chk({ctl_oe, ad_oe, addr_hi_oe}, 3'b000);
		ahb(1'b0, CBI_OFS_STAT, 32'h0);
		chk(q[CBI_ST_BUS_GRANT_ACK], 1'b1);
		n = rd_low;
		cmd(CBI_CMD_RD);
		wt(20);
		chk(rd_low, n);
		hold_req <= 1'b0;
		while (bus_grant_ack !== 1'b0) wt(1);
		wt(2);
		chk(ctl_oe, 1'b1);
		idle;
		slow <= 1'b0;
		$display("hold test done");
	endtask : t_hold
	task t_irq;
		restart_irq <= 3'b111;
		ahb(1'b1, CBI_OFS_CMD, 32'h88);
		wt(6);
		cmd(CBI_CMD_SAMPLE);
		idle;
		ahb(1'b0, CBI_OFS_STAT, 32'h0);
		chk(q[CBI_ST_TAKEN], 1'b0);
		cmd(CBI_CMD_DI);
		ahb(1'b1, CBI_OFS_MASK, 32'h08);
		cmd(CBI_CMD_HALT);
		wt(4);
		chk(ctl_oe, 1'b0);
		nonmaskable_irq <= 1'b1;
		wt(6);
		ahb(1'b0, CBI_OFS_STAT, 32'h0);
		chk(q[15:8], CBI_VEC_NMI);
		chk(q[CBI_ST_HALT], 1'b0);
		nonmaskable_irq <= 1'b0;
		general_irq <= 1'b1;
		vecs = '{CBI_VEC_R75, CBI_VEC_R65, CBI_VEC_R55, CBI_VEC_EXT};
		for (int i = 0; i < 4; i++) begin
			ahb(1'b1, CBI_OFS_CMD, 32'h88);
			ahb(1'b0, CBI_OFS_ADDR, 32'h0);
			a0 = q;
			n = ack_low;
			wt(6);
			cmd(CBI_CMD_SAMPLE);
			idle;
			ahb(1'b0, CBI_OFS_STAT, 32'h0);
			chk(q[15:8], vecs[i]);
			chk(ack_low - n, (i == 3) ? 4 : 0);
			ahb(1'b0, CBI_OFS_MASK, 32'h0);
			chk(q[CBI_RIM_IE], 1'b0);
			ahb(1'b0, CBI_OFS_ADDR, 32'h0);
			chk(q, a0);
			if (i < 3) restart_irq[2 - i] <= 1'b0;
			wt(4);
		end
		ahb(1'b0, CBI_OFS_DATA, 32'h0);
		chk(q[7:0], 8'hFF);
		chk(io_or_memory_select, 1'b1);
		general_irq <= 1'b0;
		$display("interrupt test done");
	endtask : t_irq
	task t_serial;
		ahb(1'b1, CBI_OFS_MASK, 32'hC0);
		wt(2);
		chk(serial_out_line, 1'b1);
		ahb(1'b1, CBI_OFS_MASK, 32'h40);
		wt(2);
		chk(serial_out_line, 1'b0);
		serial_in_line <= 1'b1;
		wt(4);
		ahb(1'b0, CBI_OFS_MASK, 32'h0);
		chk(q[CBI_RIM_SID], 1'b1);
		$display("serial test done");
	endtask : t_serial
	task t_rst_in;
		ahb(1'b1, CBI_OFS_ADDR, 32'h0055);
		ahb(1'b1, CBI_OFS_CMD, 32'h08);
		reset_input <= 1'b1;
		wt(10);
		chk({system_reset_out, ctl_oe, ad_oe, addr_hi_oe}, 4'b1000);
		reset_input <= 1'b0;
		wt(10);
		chk(system_reset_out, 1'b0);
		ahb(1'b0, CBI_OFS_ADDR, 32'h0);
		chk(q, 32'h0);
		ahb(1'b0, CBI_OFS_MASK, 32'h0);
		chk(q[CBI_RIM_IE], 1'b0);
		$display("reset input test done");
	endtask : t_rst_in
	task stop_test;
		$display("checked %0d, wrong %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	initial begin
		#200000;
		miscompares++;
		stop_test;
	end
	initial begin
		nrst = 0; hsel = 0; htrans = 0; hwrite = 0; haddr = 0; hwdata = 0; hsize = 3'h2;
		hold_req = 0; general_irq = 0; restart_irq = 0; nonmaskable_irq = 0;
		reset_input = 0; serial_in_line = 0; slow = 0;
		wt(6);
		nrst <= 1'b1;
		wt(1);
		t_reset;
		t_bus;
		t_hold;
		t_irq;
		t_serial;
		t_rst_in;
		stop_test;
	end
endmodule : cbi_ctrl_test
`default_nettype wire
